// >>> hdl/regulator_status_pkg.sv
package regulator_status_pkg;

    // ----------------------------------------------------------------
    // Register offsets on the serial port.
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SETTING_A = 8'h00;
    localparam logic [7:0] ADDR_SETTING_B = 8'h01;
    localparam logic [7:0] ADDR_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_IDENT = 8'h03;
    localparam logic [7:0] ADDR_REVISION = 8'h04;
    localparam logic [7:0] ADDR_MONITOR = 8'h05;
    localparam logic [7:0] ADDR_MASK = 8'h06;
    localparam logic [7:0] ADDR_LATCH = 8'h07;
    localparam logic [7:0] ADDR_STEP = 8'h01;

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int BANK_ENABLE_BIT = 7;
    localparam int CTRL_BLEED_BIT = 7;
    localparam int CTRL_SLEW_LSB = 4;
    localparam int CTRL_RANGE_BIT = 3;
    localparam int CTRL_RESET_BIT = 2;
    localparam int CTRL_MODE_A_BIT = 0;
    localparam int CTRL_MODE_B_BIT = 1;
    localparam int EVENT_WIDTH = 5;

    // ----------------------------------------------------------------
    // Reset values.
    // ----------------------------------------------------------------
    localparam logic [7:0] SETTING_RESET = 8'h80;
    localparam logic [7:0] CONTROL_RESET = 8'h80;
    localparam logic [4:0] MASK_RESET = 5'h1F;
    localparam logic [4:0] LATCH_RESET = 5'h00;
    localparam logic [2:0] MASK_RESERVED_READ = 3'h7;
    localparam logic [2:0] LATCH_RESERVED_READ = 3'h0;
    localparam logic [3:0] REVISION_RESERVED_READ = 4'h0;
    // Arbitrary identity values, chosen only to be recognisable.
    localparam logic [7:0] IDENT_DEFAULT = 8'h5C;
    localparam logic [3:0] REVISION_DEFAULT = 4'h1;
    localparam logic [6:0] DEVICE_ADDRESS_DEFAULT = 7'h2A;

    // ----------------------------------------------------------------
    // Fault timing, counted on the internal reference clock.
    // ----------------------------------------------------------------
    localparam int PERSIST_TIME_US = 250;
    localparam int HICCUP_TIME_MS = 5;
    localparam int REF_CLK_KHZ = 15625;
    localparam int PERSIST_CYCLES_DEFAULT = (PERSIST_TIME_US * REF_CLK_KHZ + 999) / 1000;
    localparam int HICCUP_CYCLES_DEFAULT = HICCUP_TIME_MS * REF_CLK_KHZ;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Serial slave states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEV = 4'h1,
        ST_DACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PACK = 4'h6,
        ST_WR = 4'h7,
        ST_WACK = 4'h5,
        ST_RD = 4'h4,
        ST_RACK = 4'hC
    } slave_state_type;

    // Live analog comparator flags.
    typedef struct packed {
        logic powerGood;
        logic inputLowLockout;
        logic inputHighCutoff;
        logic slewUp;
        logic slewDown;
        logic thermalTrip;
    } analog_status_type;

    // Controls handed to the power stage.
    typedef struct packed {
        logic regulatorOn;
        logic softStartGo;
        logic outputBleedEnable;
        logic forcedPwm;
        logic rangeHigh;
        logic [2:0] slewRate;
        logic [6:0] settingCode;
    } regulator_drive_type;

endpackage

// >>> hdl/regulator_status_irq_control.sv
`timescale 1ns/1ps
// How it works
// - Mode bit per bank picks PWM or skip.
// - Bleed resistor on when off and enabled.
// - Power-on reset loads all factory defaults.
// - Registers hold while supply stays up.
// - Reset bit restores defaults, range kept.
// - Monitor shows live status flags.
// - Mask and latch mirror status, enable inverted.
// - Only unmasked events latch; masks start set.
// - Alert pin low while any latch bit set.
// - Latch read clears; ongoing events stay set.
// - Alert survives lockout, cleared by power-on reset.
// - Lockout stops regulator, registers untouched.
// - Leaving lockout while enabled restarts soft-start.
// - Over-voltage stops regulator, restarts with soft-start.
// - Monitor bit 7 set only when output good.
// - Persistent overcurrent halts, retries after hiccup.
// - Thermal trip pauses switching, shows and latches.
// - Slave only, standard and fast rates.
// - Data edges while clock high: start, stop.
// - Data changes only while clock low.
// - Receiver acknowledges each byte on ninth pulse.
// - Register pointer steps after each acknowledged data byte.
module regulator_status_irq_control
    import regulator_status_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDRESS = DEVICE_ADDRESS_DEFAULT,
    parameter logic [6:0] SETTING_A_DEFAULT = 7'h00,
    parameter logic [6:0] SETTING_B_DEFAULT = 7'h00,
    parameter logic RANGE_DEFAULT = 1'b0,
    parameter logic [1:0] MODE_DEFAULT = 2'h0,
    parameter int PERSIST_CYCLES = PERSIST_CYCLES_DEFAULT,
    parameter int HICCUP_CYCLES = HICCUP_CYCLES_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic refClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic alertIn,
    output logic alertOut,
    output logic alertOeN,
    input wire logic enPin,
    input wire logic voltageBankPickPin,
    input wire logic overCurrent,
    input wire analog_status_type analogIn,
    output regulator_drive_type driveOut
);

    localparam int SYNC_W = 10;
    localparam int CNT_W = $clog2(HICCUP_CYCLES + PERSIST_CYCLES + 1);
    localparam logic [CNT_W-1:0] PERSIST_LAST = CNT_W'(PERSIST_CYCLES - 1);
    localparam logic [CNT_W-1:0] HICCUP_LAST = CNT_W'(HICCUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [SYNC_W-1:0] pinMeta_reg;
    logic [SYNC_W-1:0] pinSync_reg;
    logic sclPrev_reg;
    logic sdaPrev_reg;
    logic scl;
    logic sda;
    logic enLevel;
    logic bankB;
    analog_status_type statusNow;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    slave_state_type state_reg;
    logic [3:0] bitCnt_reg;
    logic [7:0] rxShift_reg;
    logic [7:0] txShift_reg;
    logic [7:0] ptr_reg;
    logic rwRead_reg;
    logic masterAck_reg;
    logic sdaLow_reg;
    logic wrEn;
    logic swResetReq;
    logic rdLoad;
    logic [7:0] readAddr;
    logic [7:0] readValue;
    logic [7:0] settingA_reg;
    logic [7:0] settingB_reg;
    logic [7:0] control_reg;
    logic [4:0] mask_reg;
    logic [4:0] latch_reg;
    logic resetSeen_reg;
    logic regOn_reg;
    logic regOnNow;
    logic [7:0] monitorValue;
    logic [4:0] eventNow;
    logic ocMeta_reg;
    logic ocSync_reg;
    logic [CNT_W-1:0] persistCnt_reg;
    logic [CNT_W-1:0] hiccupCnt_reg;
    logic hiccupRef_reg;
    logic hiccupMeta_reg;
    logic hiccupSync_reg;

    // ----------------------------------------------------------------
    // Pin synchronisers into the system clock.
    // ----------------------------------------------------------------

    // Two flops on each bus, enable, bank and analog pin; only the second is read.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_reg <= 10'h3FF;
            pinSync_reg <= 10'h3FF;
        end else begin
            pinMeta_reg <= {sclIn, sdaIn, enPin, voltageBankPickPin, analogIn};
            pinSync_reg <= pinMeta_reg;
        end
    end

    assign scl = pinSync_reg[9];
    assign sda = pinSync_reg[8];
    assign enLevel = pinSync_reg[7];
    assign bankB = pinSync_reg[6];
    assign statusNow = pinSync_reg[5:0];

    // Delayed copies for edge detection on the bus lines.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end else begin
            sclPrev_reg <= scl;
            sdaPrev_reg <= sda;
        end
    end

    // Bus conditions: data edges with the clock held high.
    assign sclRise = scl && !sclPrev_reg;
    assign sclFall = !scl && sclPrev_reg;
    assign startCond = scl && sclPrev_reg && sdaPrev_reg && !sda;
    assign stopCond = scl && sclPrev_reg && !sdaPrev_reg && sda;

    // ----------------------------------------------------------------
    // Serial slave engine.
    // ----------------------------------------------------------------

    // Register strobes derived from the engine position.
    assign wrEn = sclFall && (state_reg == ST_WR) && (bitCnt_reg == BYTE_BITS);
    assign swResetReq = wrEn && (ptr_reg == ADDR_CONTROL) && rxShift_reg[CTRL_RESET_BIT];
    assign rdLoad = sclFall && (((state_reg == ST_DACK) && rwRead_reg) ||
                                ((state_reg == ST_RACK) && masterAck_reg));
    assign readAddr = (state_reg == ST_RACK) ? ptr_reg + ADDR_STEP : ptr_reg;

    // Slave-only state machine; it never drives the clock line.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            rxShift_reg <= 8'h00;
            txShift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rwRead_reg <= 1'b0;
            masterAck_reg <= 1'b0;
            sdaLow_reg <= 1'b0;
        end else if (startCond) begin
            state_reg <= ST_DEV;
            bitCnt_reg <= 4'h0;
            sdaLow_reg <= 1'b0;
        end else if (stopCond) begin
            state_reg <= ST_IDLE;
            sdaLow_reg <= 1'b0;
        end else if (sclRise) begin
            // Data is sampled on the rising clock edge only.
            case (state_reg)
                ST_DEV, ST_PTR, ST_WR: begin
                    rxShift_reg <= {rxShift_reg[6:0], sda};
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                end
                ST_RD: begin
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                end
                ST_RACK: begin
                    masterAck_reg <= !sda;
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            // The data line is only changed while the clock is low.
            case (state_reg)
                ST_DEV: begin
                    if (bitCnt_reg == BYTE_BITS) begin
                        if (rxShift_reg[7:1] == DEVICE_ADDRESS) begin
                            sdaLow_reg <= 1'b1;
                            rwRead_reg <= rxShift_reg[0];
                            state_reg <= ST_DACK;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_DACK: begin
                    bitCnt_reg <= 4'h0;
                    if (rwRead_reg) begin
                        txShift_reg <= readValue;
                        sdaLow_reg <= !readValue[7];
                        state_reg <= ST_RD;
                    end else begin
                        sdaLow_reg <= 1'b0;
                        state_reg <= ST_PTR;
                    end
                end
                ST_PTR: begin
                    if (bitCnt_reg == BYTE_BITS) begin
                        ptr_reg <= rxShift_reg;
                        sdaLow_reg <= 1'b1;
                        state_reg <= ST_PACK;
                    end
                end
                ST_PACK: begin
                    sdaLow_reg <= 1'b0;
                    bitCnt_reg <= 4'h0;
                    state_reg <= ST_WR;
                end
                ST_WR: begin
                    if (bitCnt_reg == BYTE_BITS) begin
                        sdaLow_reg <= 1'b1;
                        state_reg <= ST_WACK;
                    end
                end
                ST_WACK: begin
                    sdaLow_reg <= 1'b0;
                    bitCnt_reg <= 4'h0;
                    ptr_reg <= ptr_reg + ADDR_STEP;
                    state_reg <= ST_WR;
                end
                ST_RD: begin
                    if (bitCnt_reg == BYTE_BITS) begin
                        sdaLow_reg <= 1'b0;
                        state_reg <= ST_RACK;
                    end else begin
                        txShift_reg <= {txShift_reg[6:0], 1'b0};
                        sdaLow_reg <= !txShift_reg[6];
                    end
                end
                ST_RACK: begin
                    bitCnt_reg <= 4'h0;
                    if (masterAck_reg) begin
                        ptr_reg <= readAddr;
                        txShift_reg <= readValue;
                        sdaLow_reg <= !readValue[7];
                        state_reg <= ST_RD;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Open-drain data line: the engine only ever pulls low.
    assign sdaOut = 1'b0;
    assign sdaOeN = !sdaLow_reg;

    // ----------------------------------------------------------------
    // Register file.
    // ----------------------------------------------------------------

    // Configuration registers, held until power-on or software reset.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settingA_reg <= SETTING_RESET | {1'b0, SETTING_A_DEFAULT};
            settingB_reg <= SETTING_RESET | {1'b0, SETTING_B_DEFAULT};
            control_reg <= CONTROL_RESET | {4'h0, RANGE_DEFAULT, 1'b0, MODE_DEFAULT};
            mask_reg <= MASK_RESET;
        end else if (swResetReq) begin
            // The range bit survives so a running output is not rescaled.
            settingA_reg <= SETTING_RESET | {1'b0, SETTING_A_DEFAULT};
            settingB_reg <= SETTING_RESET | {1'b0, SETTING_B_DEFAULT};
            control_reg <= CONTROL_RESET | {4'h0, control_reg[CTRL_RANGE_BIT], 1'b0, MODE_DEFAULT};
            mask_reg <= MASK_RESET;
        end else if (wrEn) begin
            case (ptr_reg)
                ADDR_SETTING_A: settingA_reg <= rxShift_reg;
                ADDR_SETTING_B: settingB_reg <= rxShift_reg;
                ADDR_CONTROL: control_reg <= rxShift_reg & ~(8'h01 << CTRL_RESET_BIT);
                ADDR_MASK: mask_reg <= rxShift_reg[4:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky software reset marker, cleared when the monitor is read.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resetSeen_reg <= 1'b0;
        end else if (swResetReq) begin
            resetSeen_reg <= 1'b1;
        end else if (rdLoad && (readAddr == ADDR_MONITOR)) begin
            resetSeen_reg <= 1'b0;
        end
    end

    // Live status, power-good in the top bit.
    assign monitorValue = {statusNow.powerGood, statusNow.inputLowLockout,
                           statusNow.inputHighCutoff, statusNow.slewUp, statusNow.slewDown,
                           resetSeen_reg, statusNow.thermalTrip, regOn_reg};

    // Event sources; the enable source is inverted to mean turned off.
    assign eventNow = {statusNow.slewUp, statusNow.slewDown, resetSeen_reg,
                       statusNow.thermalTrip, !regOn_reg};

    // Latch: unmasked events set bits; a read clears, but a set wins.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= LATCH_RESET;
        end else if (swResetReq) begin
            latch_reg <= LATCH_RESET;
        end else if (rdLoad && (readAddr == ADDR_LATCH)) begin
            latch_reg <= eventNow & ~mask_reg;
        end else begin
            latch_reg <= latch_reg | (eventNow & ~mask_reg);
        end
    end

    // Alert pin pulled low while any latch bit is one.
    assign alertOut = 1'b0;
    assign alertOeN = !(|latch_reg);

    // Read data multiplexer.
    always_comb begin
        case (readAddr)
            ADDR_SETTING_A: readValue = settingA_reg;
            ADDR_SETTING_B: readValue = settingB_reg;
            ADDR_CONTROL: readValue = control_reg;
            ADDR_IDENT: readValue = IDENT_DEFAULT;
            ADDR_REVISION: readValue = {REVISION_RESERVED_READ, REVISION_DEFAULT};
            ADDR_MONITOR: readValue = monitorValue;
            ADDR_MASK: readValue = {MASK_RESERVED_READ, mask_reg};
            ADDR_LATCH: readValue = {LATCH_RESERVED_READ, latch_reg};
            default: readValue = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Regulator control.
    // ----------------------------------------------------------------

    // Enabled by pin and bank bit, stopped by any supply or thermal fault.
    assign regOnNow = enLevel
        && (bankB ? settingB_reg[BANK_ENABLE_BIT] : settingA_reg[BANK_ENABLE_BIT])
        && !statusNow.inputLowLockout
        && !statusNow.inputHighCutoff
        && !statusNow.thermalTrip
        && !hiccupSync_reg;

    // Registered drive to the power stage; soft-start on every turn-on.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regOn_reg <= 1'b0;
            driveOut <= '0;
        end else begin
            regOn_reg <= regOnNow;
            driveOut.regulatorOn <= regOnNow;
            driveOut.softStartGo <= regOnNow && !regOn_reg;
            driveOut.outputBleedEnable <= !regOnNow && control_reg[CTRL_BLEED_BIT];
            driveOut.forcedPwm <= bankB ? control_reg[CTRL_MODE_B_BIT] : control_reg[CTRL_MODE_A_BIT];
            driveOut.rangeHigh <= control_reg[CTRL_RANGE_BIT];
            driveOut.slewRate <= control_reg[CTRL_SLEW_LSB +: 3];
            driveOut.settingCode <= bankB ? settingB_reg[6:0] : settingA_reg[6:0];
        end
    end

    // ----------------------------------------------------------------
    // Hiccup timing on the reference clock.
    // ----------------------------------------------------------------

    // Overcurrent flag synchronised into the reference domain.
    always_ff @(posedge refClk or negedge rst_n) begin
        if (!rst_n) begin
            ocMeta_reg <= 1'b0;
            ocSync_reg <= 1'b0;
        end else begin
            ocMeta_reg <= overCurrent;
            ocSync_reg <= ocMeta_reg;
        end
    end

    // Persistence count restarts whenever the fault goes away.
    always_ff @(posedge refClk or negedge rst_n) begin
        if (!rst_n) begin
            persistCnt_reg <= '0;
        end else if (!ocSync_reg || hiccupRef_reg) begin
            persistCnt_reg <= '0;
        end else if (persistCnt_reg != PERSIST_LAST) begin
            persistCnt_reg <= persistCnt_reg + CNT_ONE;
        end
    end

    // Halt after persistence, then retry soft-start after the wait.
    always_ff @(posedge refClk or negedge rst_n) begin
        if (!rst_n) begin
            hiccupRef_reg <= 1'b0;
            hiccupCnt_reg <= '0;
        end else if (hiccupRef_reg) begin
            if (hiccupCnt_reg == HICCUP_LAST) begin
                hiccupRef_reg <= 1'b0;
                hiccupCnt_reg <= '0;
            end else begin
                hiccupCnt_reg <= hiccupCnt_reg + CNT_ONE;
            end
        end else if (ocSync_reg && (persistCnt_reg == PERSIST_LAST)) begin
            hiccupRef_reg <= 1'b1;
        end
    end

    // Hiccup level carried back into the system clock by two flops.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hiccupMeta_reg <= 1'b0;
            hiccupSync_reg <= 1'b0;
        end else begin
            hiccupMeta_reg <= hiccupRef_reg;
            hiccupSync_reg <= hiccupMeta_reg;
        end
    end

endmodule // regulator_status_irq_control

// >>> verification/regulator_status_irq_control_properties.sv
`timescale 1ns/1ps
// Watches the pins of the regulator control block.
module regulator_checks
    import regulator_status_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic refClk,
    input wire logic sclIn,
    input wire logic overCurrent,
    input wire logic sdaOeN,
    input wire logic alertOeN,
    input wire analog_status_type analogIn,
    input wire regulator_drive_type driveOut
);
    // Power stage and serial port relations.
    a_bleed_when_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        driveOut.regulatorOn |-> !driveOut.outputBleedEnable) else $error("Bleed while on.");
    a_lockout_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
        analogIn.inputLowLockout [*8] |-> !driveOut.regulatorOn) else $error("On in lockout.");
    a_turn_on_ramps: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(driveOut.regulatorOn) |-> ##[0:1] driveOut.softStartGo) else $error("No ramp.");
    a_hiccup_halts: assert property (@(posedge refClk) disable iff (!rst_n)
        $rose(overCurrent) ##1 overCurrent [*8] ##1 overCurrent [*6] |-> !driveOut.regulatorOn)
        else $error("No halt.");
    a_sda_clock_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(sdaOeN) |-> !sclIn) else $error("Data moved with clock high.");
    a_ack_stands: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(sdaOeN) |=> !sdaOeN [*8]) else $error("Pull too short.");
    a_alert_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(alertOeN) |-> !sclIn) else $error("Alert freed off a read.");
    a_reset_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(rst_n) |-> alertOeN && sdaOeN && !driveOut.regulatorOn) else $error("Active at reset.");
    // Main scenarios reached.
    c_ack: cover property (@(posedge clk_sys) $fell(sdaOeN));
    c_alert: cover property (@(posedge clk_sys) $fell(alertOeN));
    c_halt: cover property (@(posedge clk_sys) overCurrent && $fell(driveOut.regulatorOn));
endmodule // regulator_checks

bind regulator_status_irq_control regulator_checks regulator_checks_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .refClk(refClk), .sclIn(sclIn), .overCurrent(overCurrent),
    .sdaOeN(sdaOeN), .alertOeN(alertOeN), .analogIn(analogIn), .driveOut(driveOut));

// >>> verification/serial_host_model.sv
`timescale 1ns/1ps
// Serial bus master; a released line reads high through its pull-up.
module serial_host_model (
    input wire logic clk_sys,
    input wire logic sdaWire,
    output logic sclLine,
    output logic sdaDrive
);
    // The bus starts idle with both lines high.
    initial begin
        sclLine = 1'b1;
        sdaDrive = 1'b1;
    end
    // A quarter bit, stepped on falling clock edges.
    task automatic quarter;
        repeat (25) @(negedge clk_sys);
    endtask
    // Start or repeated start when isStart is set, stop otherwise.
    task automatic cond(input logic isStart);
        sdaDrive = isStart;
        quarter;
        sclLine = 1'b1;
        quarter;
        sdaDrive = !isStart;
        quarter;
        sclLine = !isStart;
    endtask
    // One byte, top bit first, then the ninth clock for the acknowledge.
    task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
        logic [8:0] word;
        word = {tx, ackIn};
        for (int i = 8; i >= 0; i--) begin
            quarter;
            sdaDrive = word[i];
            quarter;
            sclLine = 1'b1;
            quarter;
            word[i] = sdaWire;
            quarter;
            sclLine = 1'b0;
        end
        {rx, ackOut} = word;
    endtask
endmodule // serial_host_model

// >>> verification/regulator_status_irq_control_test.sv
`timescale 1ns/1ps
module regulator_status_irq_control_test;
    import regulator_status_pkg::*;
    logic clk_sys = 1'b0;
    logic refClk = 1'b0;
    logic rst_n, sclIn, sdaDrive, sdaOeN, sdaOut, alertOeN, alertOut, enPin, bankPin, overCurrent, ack;
    logic [7:0] rx;
    logic [31:0] got;
    wire sdaWire;
    analog_status_type analogIn;
    regulator_drive_type driveOut;
    int errTotal = 0;
    int samplesChecked = 0;
    // Offset, value written, value read back; identity is read only and 0x09 unmapped.
    logic [23:0] rows [4] = '{24'h009595, 24'h061DFD, {ADDR_IDENT, 8'h00, IDENT_DEFAULT}, 24'h093300};
    // Open-drain data wire and the two unrelated clocks.
    assign sdaWire = sdaDrive & (sdaOeN | sdaOut);
    always #5 clk_sys = ~clk_sys;
    initial begin
        #1.3;
        forever #32 refClk = ~refClk;
    end
    regulator_status_irq_control #(.PERSIST_CYCLES(8), .HICCUP_CYCLES(40)) regulator_status_irq_control_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .refClk(refClk), .sclIn(sclIn), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .alertIn(alertOeN), .alertOut(alertOut), .alertOeN(alertOeN), .enPin(enPin),
        .voltageBankPickPin(bankPin), .overCurrent(overCurrent), .analogIn(analogIn), .driveOut(driveOut));
    serial_host_model serial_host_model_i (.clk_sys(clk_sys), .sdaWire(sdaWire), .sclLine(sclIn), .sdaDrive(sdaDrive));
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic giveVerdict;
        if (errTotal == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Start, write address and register pointer; then data bytes or a read.
    task automatic point(input logic [7:0] a);
        serial_host_model_i.cond(1'b1);
        serial_host_model_i.xfer({DEVICE_ADDRESS_DEFAULT, 1'b0}, 1'b1, rx, ack);
        chk(ack, 1'h0);
        serial_host_model_i.xfer(a, 1'b1, rx, ack);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        point(a);
        serial_host_model_i.xfer(d, 1'b1, rx, ack);
        chk(ack, 1'h0);
        serial_host_model_i.cond(1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        point(a);
        serial_host_model_i.cond(1'b1);
        serial_host_model_i.xfer({DEVICE_ADDRESS_DEFAULT, 1'b1}, 1'b1, rx, ack);
        got = '0;
        for (int k = n - 1; k >= 0; k--) begin
            serial_host_model_i.xfer(8'hFF, k == 0, rx, ack);
            got = {got[23:0], rx};
        end
        serial_host_model_i.cond(1'b0);
    endtask
    task automatic waitRef(input int n);
        repeat (n) @(posedge refClk);
        @(negedge clk_sys);
    endtask
    // Reset, register rows, then events, modes, software reset and hiccup.
    initial begin
        rst_n = 1'b0;
        {enPin, bankPin, overCurrent} = 3'h4;
        analogIn = 6'h20;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (10) @(negedge clk_sys);
        rd(ADDR_MASK, 2);
        chk(got, 32'hFF00);
        for (int i = 0; i < 4; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], 1);
            chk(got, rows[i][7:0]);
        end
        analogIn = 6'h31;
        repeat (20) @(negedge clk_sys);
        chk(alertOeN, 1'h0);
        rd(ADDR_LATCH, 1);
        chk({got[7:0], alertOeN}, 9'h004);
        analogIn = 6'h20;
        rd(ADDR_LATCH, 1);
        chk({got[7:0], alertOeN}, 9'h005);
        enPin = 1'b0;
        repeat (10) @(negedge clk_sys);
        chk(driveOut.outputBleedEnable, 1'h1);
        wr(ADDR_CONTROL, 8'h02);
        chk({driveOut.outputBleedEnable, driveOut.forcedPwm}, 2'h0);
        bankPin = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk(driveOut.forcedPwm, 1'h1);
        {enPin, bankPin} = 2'h2;
        wr(ADDR_CONTROL, 8'h04);
        rd(ADDR_CONTROL, 4);
        chk(got, {CONTROL_RESET, IDENT_DEFAULT, REVISION_RESERVED_READ, REVISION_DEFAULT, 8'h85});
        overCurrent = 1'b1;
        waitRef(24);
        overCurrent = 1'b0;
        waitRef(10);
        chk(driveOut.regulatorOn, 1'h0);
        waitRef(60);
        chk(driveOut.regulatorOn, 1'h1);
        analogIn = 6'h0E;
        rd(ADDR_MONITOR, 1);
        chk({got[7:0], driveOut.regulatorOn}, 9'h070);
        analogIn = 6'h20;
        repeat (10) @(negedge clk_sys);
        chk(driveOut.regulatorOn, 1'h1);
        giveVerdict;
    end
endmodule // regulator_status_irq_control_test
